// file: verilog/stc_map.vh
// Purpose : Register map, field layout and timing counts of the scan timer/counter unit
// Assumes : Included by bare name; 32-bit AXI4-Lite register words
// Notes   : Definitions only
`ifndef STC_MAP_VH
`define STC_MAP_VH

// ----------------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------------
`define STC_OFS_CTRL      8'h00
`define STC_OFS_CMD       8'h04
`define STC_OFS_SETVAL    8'h08
`define STC_OFS_STATUS    8'h0C
`define STC_OFS_CURVAL    8'h10
`define STC_OFS_CVWRITE   8'h14
`define STC_OFS_SCANEND   8'h18
`define STC_OFS_TICKS     8'h1C

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define STC_CTRL_RUN      0
`define STC_CMD_IDX_LO    0
`define STC_CMD_KIND_LO   8
`define STC_CMD_BASE_LO   10
`define STC_CMD_COND      12
`define STC_CMD_CLEAR     13
`define STC_STAT_OUT      0
`define STC_STAT_BUSY     1
`define STC_STAT_FIRST    2
`define STC_STAT_RUN      3
`define STC_CVW_IDX_LO    0
`define STC_CVW_CNT       8
`define STC_CVW_VAL_LO    16

// ----------------------------------------------------------------------
// Encodings
// ----------------------------------------------------------------------
`define STC_KIND_ONDELAY  2'b00
`define STC_KIND_SSHOT    2'b01
`define STC_KIND_UPCNT    2'b10
`define STC_BASE_10MS     2'b00
`define STC_BASE_100MS    2'b01
`define STC_BASE_1S       2'b10
`define STC_RESP_OKAY     2'b00
`define STC_RESP_SLVERR   2'b10
`define STC_CV_MAX        16'hFFFF

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define STC_CLK_PERIOD_NS 10
`define STC_BASE_10MS_NS  10000000
`define STC_BASE_100MS_NS 100000000
`define STC_BASE_1S_NS    1000000000
`define STC_CYC_10MS      (`STC_BASE_10MS_NS / `STC_CLK_PERIOD_NS)
`define STC_CYC_100MS     (`STC_BASE_100MS_NS / `STC_CLK_PERIOD_NS)
`define STC_CYC_1S        (`STC_BASE_1S_NS / `STC_CLK_PERIOD_NS)

`endif

// file: verilog/stc_tick_gen.v
// Purpose : Free-running tick stamps for the three time bases
// Assumes : aclk at 100 MHz, synchronous active-low reset
// Notes   : Stamps wrap at 16 bits; users take differences modulo 2^16
`timescale 1ns/10ps
`include "stc_map.vh"

module stc_tick_gen #(
    parameter CYC_10MS  = `STC_CYC_10MS,
    parameter CYC_100MS = `STC_CYC_100MS,
    parameter CYC_1S    = `STC_CYC_1S
) (
    input  wire        aclk,
    input  wire        aresetn,
    output reg  [15:0] stamp_10ms_reg,
    output reg  [15:0] stamp_100ms_reg,
    output reg  [15:0] stamp_1s_reg
);
    reg  [31:0] div_10ms_reg;
    reg  [31:0] div_100ms_reg;
    reg  [31:0] div_1s_reg;

    // ------------------------------------------------------------------
    // Dividers, each base kept independent so a short sim value is exact
    // ------------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            div_10ms_reg    <= 32'h0000_0000;
            div_100ms_reg   <= 32'h0000_0000;
            div_1s_reg      <= 32'h0000_0000;
            stamp_10ms_reg  <= 16'h0000;
            stamp_100ms_reg <= 16'h0000;
            stamp_1s_reg    <= 16'h0000;
        end else begin
            if (div_10ms_reg >= CYC_10MS - 1) begin
                div_10ms_reg   <= 32'h0000_0000;
                stamp_10ms_reg <= stamp_10ms_reg + 16'h0001;
            end else begin
                div_10ms_reg <= div_10ms_reg + 32'h0000_0001;
            end
            if (div_100ms_reg >= CYC_100MS - 1) begin
                div_100ms_reg   <= 32'h0000_0000;
                stamp_100ms_reg <= stamp_100ms_reg + 16'h0001;
            end else begin
                div_100ms_reg <= div_100ms_reg + 32'h0000_0001;
            end
            if (div_1s_reg >= CYC_1S - 1) begin
                div_1s_reg   <= 32'h0000_0000;
                stamp_1s_reg <= stamp_1s_reg + 16'h0001;
            end else begin
                div_1s_reg <= div_1s_reg + 32'h0000_0001;
            end
        end
    end
endmodule // stc_tick_gen

// file: verilog/stc_scan_timer_counter.v
// Purpose : Scan-driven on-delay timers, single-shot timers and up counters behind AXI4-Lite
// Assumes : Scan engine issues one CMD write per instruction per scan, SCANEND at end of scan
// Notes   : 256 timer numbers and 256 counter numbers held in one state memory
//
// Summary of operation
// - On-delay output on when value exceeds set
// - Time base 10 ms, 100 ms or 1 s
// - Timer numbers run 0 to 255
// - Overwritten current value used at once
// - On-delay rereads set value every scan
// - Single shot on after edge, off past set
// - No single-shot edge at first run scan
// - Single shot rereads set value every scan
// - Counter adds one per edge, on at set
// - Clear forces counter output off, value zero
// - Counter ignores edges while clear is on
// - No counter edge at first run scan
// - Counter rereads set value every scan
// - Up count saturates at 65535
// - Set value zero keeps counter output on unless clear is on
// - Accuracy minus one tick to plus scan
`timescale 1ns/10ps
`include "stc_map.vh"

module stc_scan_timer_counter #(
    parameter CYC_10MS  = `STC_CYC_10MS,
    parameter CYC_100MS = `STC_CYC_100MS,
    parameter CYC_1S    = `STC_CYC_1S
) (
    input  wire        aclk,
    input  wire        aresetn,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready
);
    localparam ST_INIT = 2'h0;
    localparam ST_IDLE = 2'h1;
    localparam ST_READ = 2'h2;
    localparam ST_EXEC = 2'h3;

    // ------------------------------------------------------------------
    // State memory and control registers
    // ------------------------------------------------------------------
    // Entry: {prev_cond, out, stamp[15:0], cv[15:0]}
    reg  [33:0] state_mem [0:511];
    reg  [33:0] entry_reg;
    reg  [1:0]  fsm_reg;
    reg  [8:0]  init_idx_reg;
    reg  [7:0]  aw_addr_reg;
    reg         aw_held_reg;
    reg  [31:0] w_data_reg;
    reg         w_held_reg;
    reg         run_reg;
    reg         first_scan_reg;
    reg  [15:0] setval_reg;
    reg  [13:0] cmd_reg;
    reg         last_out_reg;
    reg  [15:0] last_cv_reg;
    reg  [33:0] entry_next;
    reg  [15:0] now_stamp;
    reg  [15:0] cv_acc;
    reg         edge_seen;
    reg  [31:0] rd_data;
    reg         rd_ok;
    wire [15:0] stamp_10ms;
    wire [15:0] stamp_100ms;
    wire [15:0] stamp_1s;
    wire        wr_go;
    wire [8:0]  cmd_addr;

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------
    function [15:0] sat_add;
        input [15:0] a;
        input [15:0] b;
        reg   [16:0] s;
        begin
            s = {1'b0, a} + {1'b0, b};
            sat_add = s[16] ? `STC_CV_MAX : s[15:0];
        end
    endfunction

    function is_reg;
        input [7:0] addr;
        begin
            is_reg = (addr[1:0] == 2'b00) && (addr <= `STC_OFS_TICKS);
        end
    endfunction

    // Register write strobe, decoded in several places
    function wr_hit;
        input       go;
        input [7:0] addr;
        input [7:0] ofs;
        begin
            wr_hit = go && (addr == ofs);
        end
    endfunction

    stc_tick_gen #(
        .CYC_10MS  (CYC_10MS),
        .CYC_100MS (CYC_100MS),
        .CYC_1S    (CYC_1S)
    ) u_tick (
        .aclk            (aclk),
        .aresetn         (aresetn),
        .stamp_10ms_reg  (stamp_10ms),
        .stamp_100ms_reg (stamp_100ms),
        .stamp_1s_reg    (stamp_1s)
    );

    // ------------------------------------------------------------------
    // AXI4-Lite handshakes
    // ------------------------------------------------------------------
    // Ready held low while a response waits: one write in flight at a time
    assign s_axi_awready = !aw_held_reg && !s_axi_bvalid;
    assign s_axi_wready  = !w_held_reg && !s_axi_bvalid;
    assign s_axi_arready = !s_axi_rvalid;
    assign wr_go         = aw_held_reg && w_held_reg;
    assign cmd_addr      = {cmd_reg[`STC_CMD_KIND_LO+1], cmd_reg[7:0]};

    always @* begin
        rd_ok = is_reg(s_axi_araddr);
        case (s_axi_araddr)
            `STC_OFS_CTRL:    rd_data = {31'h0000_0000, run_reg};
            `STC_OFS_CMD:     rd_data = {18'h0_0000, cmd_reg};
            `STC_OFS_SETVAL:  rd_data = {16'h0000, setval_reg};
            `STC_OFS_STATUS:  rd_data = {28'h000_0000, run_reg, first_scan_reg,
                                         (fsm_reg != ST_IDLE), last_out_reg};
            `STC_OFS_CURVAL:  rd_data = {16'h0000, last_cv_reg};
            `STC_OFS_TICKS:   rd_data = {stamp_100ms, stamp_10ms};
            default:          rd_data = 32'h0000_0000;
        endcase
    end

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg  <= 1'b0;
            w_held_reg   <= 1'b0;
            aw_addr_reg  <= 8'h00;
            w_data_reg   <= 32'h0000_0000;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= `STC_RESP_OKAY;
            s_axi_rvalid <= 1'b0;
            s_axi_rresp  <= `STC_RESP_OKAY;
            s_axi_rdata  <= 32'h0000_0000;
        end else begin
            if (s_axi_awvalid && s_axi_awready) begin
                aw_held_reg <= 1'b1;
                aw_addr_reg <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_held_reg <= 1'b1;
                w_data_reg <= s_axi_wdata;
            end
            if (wr_go) begin
                aw_held_reg  <= 1'b0;
                w_held_reg   <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= is_reg(aw_addr_reg) ? `STC_RESP_OKAY : `STC_RESP_SLVERR;
            end else if (s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_data;
                s_axi_rresp  <= rd_ok ? `STC_RESP_OKAY : `STC_RESP_SLVERR;
            end else if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // Instruction evaluation
    // ------------------------------------------------------------------
    always @* begin
        case (cmd_reg[`STC_CMD_BASE_LO+1:`STC_CMD_BASE_LO])
            `STC_BASE_10MS:  now_stamp = stamp_10ms;
            `STC_BASE_100MS: now_stamp = stamp_100ms;
            default:         now_stamp = stamp_1s;
        endcase
        // Elapsed whole ticks; partial tick lost at start gives the early bound
        cv_acc     = sat_add(entry_reg[15:0], now_stamp - entry_reg[31:16]);
        // Edge from this scan's value against last scan's, masked on first scan
        edge_seen  = cmd_reg[`STC_CMD_COND] && !entry_reg[33] && !first_scan_reg;
        entry_next = entry_reg;
        entry_next[33] = cmd_reg[`STC_CMD_COND];
        case (cmd_reg[`STC_CMD_KIND_LO+1:`STC_CMD_KIND_LO])
            `STC_KIND_ONDELAY: begin
                if (!cmd_reg[`STC_CMD_COND]) begin
                    entry_next[15:0]  = 16'h0000;
                    entry_next[31:16] = now_stamp;
                    entry_next[32]    = 1'b0;
                end else if (!entry_reg[33]) begin
                    entry_next[15:0]  = 16'h0000;
                    entry_next[31:16] = now_stamp;
                    entry_next[32]    = 1'b0;
                end else begin
                    entry_next[15:0]  = cv_acc;
                    entry_next[31:16] = now_stamp;
                    entry_next[32]    = (cv_acc > setval_reg);
                end
            end
            `STC_KIND_SSHOT: begin
                entry_next[31:16] = now_stamp;
                if (edge_seen) begin
                    entry_next[15:0] = 16'h0000;
                    entry_next[32]   = 1'b1;
                end else if (entry_reg[32]) begin
                    entry_next[15:0] = cv_acc;
                    entry_next[32]   = !(cv_acc > setval_reg);
                end
            end
            default: begin
                if (cmd_reg[`STC_CMD_CLEAR]) begin
                    entry_next[15:0] = 16'h0000;
                    entry_next[32]   = 1'b0;
                end else begin
                    if (edge_seen && entry_reg[15:0] != `STC_CV_MAX)
                        entry_next[15:0] = entry_reg[15:0] + 16'h0001;
                    // Zero set value keeps output on
                    entry_next[32] = (entry_next[15:0] >= setval_reg);
                end
            end
        endcase
    end

    // ------------------------------------------------------------------
    // Control registers and state memory sequencing
    // ------------------------------------------------------------------
    always @(posedge aclk) begin
        if (!aresetn) begin
            fsm_reg        <= ST_INIT;
            init_idx_reg   <= 9'h000;
            run_reg        <= 1'b0;
            first_scan_reg <= 1'b0;
            setval_reg     <= 16'h0000;
            cmd_reg        <= 14'h0000;
            last_out_reg   <= 1'b0;
            last_cv_reg    <= 16'h0000;
            entry_reg      <= 34'h0_0000_0000;
        end else begin
            if (wr_hit(wr_go, aw_addr_reg, `STC_OFS_CTRL)) begin
                run_reg <= w_data_reg[`STC_CTRL_RUN];
                if (w_data_reg[`STC_CTRL_RUN] && !run_reg)
                    first_scan_reg <= 1'b1;
            end
            if (wr_hit(wr_go, aw_addr_reg, `STC_OFS_SCANEND))
                first_scan_reg <= 1'b0;
            if (wr_hit(wr_go, aw_addr_reg, `STC_OFS_SETVAL))
                setval_reg <= w_data_reg[15:0];
            case (fsm_reg)
                ST_INIT: begin
                    // Memory has no reset of its own, so sweep it once
                    state_mem[init_idx_reg] <= 34'h0_0000_0000;
                    init_idx_reg <= init_idx_reg + 9'h001;
                    if (init_idx_reg == 9'h1FF)
                        fsm_reg <= ST_IDLE;
                end
                ST_IDLE: begin
                    // Commands in the sweep or mid-evaluation are dropped; engine polls busy
                    if (wr_hit(wr_go, aw_addr_reg, `STC_OFS_CMD)) begin
                        cmd_reg <= w_data_reg[13:0];
                        fsm_reg <= ST_READ;
                    end else if (wr_hit(wr_go, aw_addr_reg, `STC_OFS_CVWRITE)) begin
                        // Stored value is what the next evaluation starts
                        state_mem[{w_data_reg[`STC_CVW_CNT], w_data_reg[7:0]}][15:0]
                            <= w_data_reg[31:16];
                    end
                end
                ST_READ: begin
                    entry_reg <= state_mem[cmd_addr];
                    fsm_reg   <= ST_EXEC;
                end
                default: begin
                    state_mem[cmd_addr] <= entry_next;
                    last_out_reg <= entry_next[32];
                    last_cv_reg  <= entry_next[15:0];
                    fsm_reg      <= ST_IDLE;
                end
            endcase
        end
    end
endmodule // stc_scan_timer_counter

// file: tb/stc_sva.sv
// Purpose: Bus handshake checks on the timer/counter unit
// Assumes: One clock, synchronous active-low reset
// Notes: Sees only the top-level ports
`timescale 1ns/10ps
module stc_sva (
    input logic        aclk,
    input logic        aresetn,
    input logic [7:0]  s_axi_awaddr,
    input logic        s_axi_awvalid,
    input logic        s_axi_awready,
    input logic [31:0] s_axi_wdata,
    input logic [3:0]  s_axi_wstrb,
    input logic        s_axi_wvalid,
    input logic        s_axi_wready,
    input logic [1:0]  s_axi_bresp,
    input logic        s_axi_bvalid,
    input logic        s_axi_bready,
    input logic [7:0]  s_axi_araddr,
    input logic        s_axi_arvalid,
    input logic        s_axi_arready,
    input logic [31:0] s_axi_rdata,
    input logic [1:0]  s_axi_rresp,
    input logic        s_axi_rvalid,
    input logic        s_axi_rready
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ------------------------------------------------------------
    // Handshakes
    // ------------------------------------------------------------
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response not held");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    write_block_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    read_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read taken while data pending");
    read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    write_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
    // Unmapped or misaligned reads answer with an error, mapped reads with OKAY
    bad_read_a: assert property (s_axi_arvalid && s_axi_arready && (s_axi_araddr >= 8'h20 || s_axi_araddr[1:0] != 2'h0)
        |=> s_axi_rresp == 2'h2) else $error("unmapped read not refused");
    good_read_a: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr < 8'h20 && s_axi_araddr[1:0] == 2'h0
        |=> s_axi_rresp == 2'h0) else $error("mapped read refused");
    reset_idle_a: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid)
        else $error("response pending after reset");
    cover property (s_axi_bvalid && s_axi_bready);
    cover property (s_axi_rvalid && s_axi_rready);
    cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule // stc_sva

bind stc_scan_timer_counter stc_sva i_sva (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// file: tb/stc_scan_engine.sv
// Purpose: Scan engine model issuing ladder instructions over AXI4-Lite
// Assumes: One transfer at a time, signals change after rising edges
// Notes: Waits end only by the bench watchdog
`timescale 1ns/10ps
`include "stc_map.vh"
module stc_scan_engine (
    input  logic        aclk,
    output logic [7:0]  awaddr,
    output logic        awvalid,
    input  logic        awready,
    output logic [31:0] wdata,
    output logic        wvalid,
    input  logic        wready,
    input  logic [1:0]  bresp,
    input  logic        bvalid,
    output logic        bready,
    output logic [7:0]  araddr,
    output logic        arvalid,
    input  logic        arready,
    input  logic [31:0] rdata,
    input  logic [1:0]  rresp,
    input  logic        rvalid,
    output logic        rready
);
    initial begin
        {awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
    end
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (awvalid && awready) awvalid <= 1'b0;
            if (wvalid && wready) wvalid <= 1'b0;
        end while (!bvalid);
        // Late ready makes the response wait a cycle
        bready <= 1'b1;
        @(posedge aclk);
        bready <= 1'b0;
        r = bresp;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        do begin
            @(posedge aclk);
            if (arvalid && arready) arvalid <= 1'b0;
        end while (!rvalid);
        rready <= 1'b1;
        @(posedge aclk);
        rready <= 1'b0;
        d = rdata;
        r = rresp;
    endtask
    // One instruction of the program: set value first, then the command
    task automatic eval(input logic [7:0] n, input logic [1:0] k, input logic [1:0] b, input logic c,
                        input logic clr, input logic [15:0] sv, output logic o, output logic [15:0] cv);
        logic [1:0]  r;
        logic [31:0] d;
        logic [1:0]  bs;
        bs = (n > 8'd63 && b == `STC_BASE_10MS) ? `STC_BASE_100MS : b;
        wr(`STC_OFS_SETVAL, {16'h0000, sv}, r);  // Word operand each scan
        wr(`STC_OFS_CMD, {18'h0, clr, c, bs, k, n}, r);
        d = 32'h0000_0002;
        while (d[`STC_STAT_BUSY]) rd(`STC_OFS_STATUS, d, r);
        o = d[`STC_STAT_OUT];
        rd(`STC_OFS_CURVAL, d, r);
        cv = d[15:0];
    endtask
endmodule // stc_scan_engine

// file: tb/testbench.sv
// Purpose: Self-checking bench for the scan timer/counter unit
// Assumes: Short time-base counts set through parameters
// Notes: Timer values allow one tick of slack
`timescale 1ns/10ps
`include "stc_map.vh"
`define CHK(n, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
    $display("MISMATCH %s expected %0h seen %0h", n, e, g); end end
module testbench;
    localparam int P10 = 40;
    localparam logic [1:0] OD = `STC_KIND_ONDELAY;
    localparam logic [1:0] SS = `STC_KIND_SSHOT;
    localparam logic [1:0] UP = `STC_KIND_UPCNT;
    logic        aclk, aresetn, o;
    logic        awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, d;
    logic [1:0]  bresp, rresp, r;
    logic [15:0] cv;
    int          num_errors = 0;
    int          n_compared = 0;
    int          p;
    stc_scan_timer_counter #(.CYC_10MS(P10), .CYC_100MS(P10 * 10), .CYC_1S(P10 * 100)) i_dut (
        .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
    stc_scan_engine i_eng (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wvalid(wvalid), .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
        .araddr(araddr), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
        .rvalid(rvalid), .rready(rready));
    initial begin
        aclk = 1'b0;
        forever #5 aclk = ~aclk;
    end
    task automatic test_done;
        $display("Compared %0d, mismatches %0d", n_compared, num_errors);
        if (num_errors == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic ev(input logic [7:0] n, input logic [1:0] k, input logic [1:0] b, input logic c,
                      input logic clr, input logic [15:0] sv, input logic eo, input logic [15:0] ecv);
        i_eng.eval(n, k, b, c, clr, sv, o, cv);
        `CHK("output bit", eo, o)
        `CHK("current value", ecv, cv)
    endtask
    initial begin
        repeat (40000) @(posedge aclk);
        num_errors++;
        test_done();
    end
    initial begin
        aresetn = 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        // Wait out the state clearing sweep
        d = 32'h0000_0002;
        while (d[`STC_STAT_BUSY]) i_eng.rd(`STC_OFS_STATUS, d, r);
        i_eng.wr(`STC_OFS_SETVAL, 32'h0000_A5C3, r);
        i_eng.rd(`STC_OFS_SETVAL, d, r);
        `CHK("setval", 32'h0000_A5C3, d)
        i_eng.rd(8'h20, d, r);
        `CHK("unmapped read", `STC_RESP_SLVERR, r)
        i_eng.wr(8'h24, 32'h0000_0001, r);
        `CHK("unmapped write", `STC_RESP_SLVERR, r)
        $display("test registers done");
        // Run start arms the first scan; numbers never shared between kinds
        i_eng.wr(`STC_OFS_CTRL, 32'h0000_0000, r);
        i_eng.wr(`STC_OFS_CTRL, 32'h0000_0001, r);
        i_eng.rd(`STC_OFS_STATUS, d, r);
        `CHK("run and first scan", 2'b11, d[3:2])
        ev(8'd5, UP, 2'h0, 1'b1, 1'b0, 16'h0002, 1'b0, 16'h0000);
        ev(8'd11, SS, 2'h0, 1'b1, 1'b0, 16'h0002, 1'b0, 16'h0000);
        i_eng.wr(`STC_OFS_SCANEND, 32'h0000_0000, r);
        i_eng.rd(`STC_OFS_STATUS, d, r);
        `CHK("first scan cleared", 2'b10, d[3:2])
        ev(8'd5, UP, 2'h0, 1'b0, 1'b0, 16'h0002, 1'b0, 16'h0000);
        ev(8'd11, SS, 2'h0, 1'b0, 1'b0, 16'h0002, 1'b0, 16'h0000);
        ev(8'd11, SS, 2'h0, 1'b1, 1'b0, 16'h0002, 1'b1, 16'h0000);
        ev(8'd5, UP, 2'h0, 1'b1, 1'b0, 16'h0002, 1'b0, 16'h0001);
        ev(8'd5, UP, 2'h0, 1'b1, 1'b0, 16'h0002, 1'b0, 16'h0001);
        ev(8'd5, UP, 2'h0, 1'b0, 1'b0, 16'h0002, 1'b0, 16'h0001);
        ev(8'd5, UP, 2'h0, 1'b1, 1'b0, 16'h0002, 1'b1, 16'h0002);
        ev(8'd5, UP, 2'h0, 1'b1, 1'b0, 16'h0005, 1'b0, 16'h0002);
        ev(8'd5, UP, 2'h0, 1'b0, 1'b1, 16'h0000, 1'b0, 16'h0000);
        ev(8'd5, UP, 2'h0, 1'b1, 1'b1, 16'h0000, 1'b0, 16'h0000);
        ev(8'd5, UP, 2'h0, 1'b1, 1'b0, 16'h0000, 1'b1, 16'h0000);
        i_eng.wr(`STC_OFS_CVWRITE, 32'hFFFF_0105, r);
        ev(8'd5, UP, 2'h0, 1'b0, 1'b0, 16'hFFFF, 1'b1, 16'hFFFF);
        ev(8'd5, UP, 2'h0, 1'b1, 1'b0, 16'hFFFF, 1'b1, 16'hFFFF);
        $display("test counter done");
        // Single shot has run some ticks since its edge
        i_eng.eval(8'd11, SS, 2'h0, 1'b1, 1'b0, 16'd1000, o, cv);
        `CHK("single shot on", 1'b1, o)
        i_eng.eval(8'd11, SS, 2'h0, 1'b1, 1'b0, 16'd1, o, cv);
        `CHK("single shot off", 1'b0, o)
        $display("test single shot done");
        for (int b = 0; b < 3; b++) begin
            p = (b == 0) ? P10 : (b == 1) ? P10 * 10 : P10 * 100;
            ev(8'd20 + b[7:0], OD, b[1:0], 1'b0, 1'b0, 16'd2, 1'b0, 16'h0000);
            ev(8'd20 + b[7:0], OD, b[1:0], 1'b1, 1'b0, 16'd2, 1'b0, 16'h0000);
            repeat (p * 3) @(posedge aclk);
            i_eng.eval(8'd20 + b[7:0], OD, b[1:0], 1'b1, 1'b0, 16'd2, o, cv);
            `CHK("delay value", 1'b1, cv >= 16'd3 && cv <= 16'd4)
            `CHK("delay past set", 1'b1, o)
            i_eng.eval(8'd20 + b[7:0], OD, b[1:0], 1'b1, 1'b0, 16'd9, o, cv);
            `CHK("delay new set", 1'b0, o)
            ev(8'd20 + b[7:0], OD, b[1:0], 1'b0, 1'b0, 16'd2, 1'b0, 16'h0000);
        end
        ev(8'd255, OD, `STC_BASE_1S, 1'b1, 1'b0, 16'd0, 1'b0, 16'h0000);
        i_eng.wr(`STC_OFS_CVWRITE, 32'h01F4_00FF, r);
        i_eng.eval(8'd255, OD, `STC_BASE_1S, 1'b1, 1'b0, 16'd499, o, cv);
        `CHK("written value", 1'b1, cv >= 16'd500 && cv <= 16'd501)
        `CHK("written out", 1'b1, o)
        $display("test on delay done");
        test_done();
    end
endmodule // testbench
